//--- rtl/csc_consts.svh
// converter sequencing control: command codes, field positions, defaults
// and timing counts as macros; included by every design file that needs them
`ifndef CSC_CONSTS_SVH
`define CSC_CONSTS_SVH
// ----------------------------------------------------------------
// command codes
// ----------------------------------------------------------------
`define CSC_CMD_OPERATION 8'h01
`define CSC_CMD_ON_OFF_CFG 8'h02
`define CSC_CMD_INPUT_TURN_ON_THRESHOLD 8'h35
`define CSC_CMD_INPUT_TURN_OFF_THRESHOLD 8'h36
`define CSC_CMD_TON_DELAY 8'h60
`define CSC_CMD_TON_RISE 8'h61
`define CSC_CMD_TOFF_DELAY 8'h64
`define CSC_CMD_TOFF_FALL 8'h65
`define CSC_CMD_STATUS 8'h79
`define CSC_CMD_GOOD_LIMITS 8'hd7
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CSC_CFG_PU 4
`define CSC_CFG_CMD 3
`define CSC_CFG_PIN 2
`define CSC_CFG_POL 1
`define CSC_CFG_CPA 0
`define CSC_OP_ON 7
`define CSC_OP_SKIP 6
// ----------------------------------------------------------------
// reset values and limits (millivolts, milliseconds)
// ----------------------------------------------------------------
`define CSC_OP_DEF 8'h00
`define CSC_CFG_DEF 8'h16
`define CSC_INPUT_TURN_ON_THRESHOLD_DEF 16'h1194
`define CSC_INPUT_TURN_ON_THRESHOLD_MIN 16'h109a
`define CSC_INPUT_TURN_ON_THRESHOLD_MAX 16'h1e46
`define CSC_INPUT_TURN_OFF_THRESHOLD_DEF 16'h0fa0
`define CSC_INPUT_TURN_OFF_THRESHOLD_MIN 16'h0fa0
`define CSC_INPUT_TURN_OFF_THRESHOLD_MAX 16'h1d4c
`define CSC_VIN_STEP 16'h00fa
`define CSC_TON_DELAY_DEF 8'h00
`define CSC_TON_RISE_DEF 8'h03
`define CSC_TOFF_DELAY_DEF 8'h00
`define CSC_TOFF_FALL_DEF 8'h03
`define CSC_MS_MAX 8'h64
`define CSC_MS_ONE 8'h01
`define CSC_LIMITS_DEF 8'h55
`define CSC_OVW_PCT 32'h00000069
`define CSC_BP6_UVLO_MV 16'h0e92
`define CSC_TRISTATE_MV 16'h00c8
`define CSC_PREBIAS_PULSES 8'h80
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CSC_CLK_NS 8
`define CSC_SYNC_LAG_NS 500
`define CSC_SYNC_LAG_CYC ((`CSC_SYNC_LAG_NS + `CSC_CLK_NS - 1) / `CSC_CLK_NS)
`define CSC_US_NS 1000
`define CSC_US_CYC (`CSC_US_NS / `CSC_CLK_NS)
`define CSC_MS_US 1000
`endif

//--- rtl/csc_pkg.sv
// converter sequencing control: shared types
// assumes nothing beyond a SystemVerilog compiler
package csc_pkg;
	typedef enum logic [2:0] {
		ST_OFF, ST_TON_WAIT, ST_RAMP_UP, ST_ON, ST_TOFF_WAIT, ST_RAMP_DOWN
	} csc_state_type;
endpackage : csc_pkg

//--- rtl/csc_sync.sv
// two-flop synchroniser for pins from outside the clock domain
// assumes the inputs are levels held for several clock periods
`timescale 1ns/1ps
module csc_sync #(
	parameter int W = 1
) (
	input wire logic clk, // system clock
	input wire logic rst, // async reset, active high
	input wire logic ce, // clock enable
	input wire logic [W-1:0] d, // asynchronous inputs
	output logic [W-1:0] q // synchronised outputs
);
	logic [W-1:0] meta_r;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta_r <= '0;
			q <= '0;
		end else if (ce) begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule : csc_sync

//--- rtl/csc_timebase.sv
// microsecond and millisecond tick generator, restartable
// assumes a 125 MHz clock; clr restarts both counts from zero
`timescale 1ns/1ps
`include "csc_consts.svh"
module csc_timebase (
	input wire logic clk, // system clock
	input wire logic rst, // async reset, active high
	input wire logic ce, // clock enable
	input wire logic clr, // restart the timebase
	output logic us_tick, // one-cycle pulse each microsecond
	output logic ms_tick // one-cycle pulse each millisecond
);
	logic [6:0] cyc_r;
	logic [9:0] us_r;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cyc_r <= 7'h00;
			us_r <= 10'h000;
			us_tick <= 1'b0;
			ms_tick <= 1'b0;
		end else if (ce) begin
			us_tick <= 1'b0;
			ms_tick <= 1'b0;
			if (clr) begin
				cyc_r <= 7'h00;
				us_r <= 10'h000;
			end else if (cyc_r == 7'(`CSC_US_CYC - 1)) begin
				cyc_r <= 7'h00;
				us_tick <= 1'b1;
				if (us_r == 10'(`CSC_MS_US - 1)) begin
					us_r <= 10'h000;
					ms_tick <= 1'b1;
				end else begin
					us_r <= us_r + 10'h001;
				end
			end else begin
				cyc_r <= cyc_r + 7'h01;
			end
		end
	end
endmodule : csc_timebase

//--- rtl/csc_top.sv
// converter sequencing control: switching clock and sync lock, input
// lockout, turn-on gating with delays, soft start/stop, prebias start-up,
// power-good and overvoltage warning.
// assumes analog readings (mV) and duty come from logic on CLK; sync,
// control and master/slave pins are asynchronous; commands are already
// decoded from the management bus into write/read strobes.
`timescale 1ns/1ps
`include "csc_consts.svh"
module csc_top import csc_pkg::*; (
	input wire logic CLK, // 125 MHz system clock
	input wire logic RST, // async reset, active high
	input wire logic CE, // clock enable, freezes all state when low
	input wire logic SYNC_PIN, // external switching clock pin
	input wire logic CONTROL_PIN, // on/off control pin
	input wire logic SLAVE_PIN, // high: unit is the parallel slave
	input wire logic [15:0] VIN_MV, // input voltage reading
	input wire logic [15:0] FB_MV, // feedback input reading
	input wire logic [15:0] VREF_MV, // final reference value
	input wire logic [15:0] BP6_MV, // internal 6 V regulator reading
	input wire logic [11:0] FREE_PERIOD, // resistor period in cycles
	input wire logic [11:0] DUTY, // high-side on-time in cycles
	input wire logic FAULT, // any fault condition present
	input wire logic CMD_WR, // command write strobe
	input wire logic CMD_RD, // command read strobe
	input wire logic [7:0] CMD_CODE, // command code
	input wire logic [15:0] CMD_DATA, // command write data
	output logic [15:0] RD_DATA, // command read data
	output logic RD_ACK, // read data valid pulse
	output logic HS_GATE, // high-side driver on
	output logic LS_GATE, // low-side driver on
	output logic [15:0] SS_REF_MV, // soft-start reference
	output logic POWER_GOOD_O, // power-good pad output, always low
	output logic POWER_GOOD_OE_N, // low while pulling power-good low
	output logic OV_WARN, // output overvoltage warning
	output logic SYNC_LOCKED, // locked to the external clock
	output logic CONVERTING // switching enabled
);
	// ----------------------------------------------------------------
	// pins and timebase
	// ----------------------------------------------------------------
	logic [2:0] pins_s;
	logic sync_s, ctl_s, slave_s, sync_d_r;
	logic us_tick, ms_tick, tb_clr;

	csc_sync #(.W(3)) u_sync (
		.clk(CLK),
		.rst(RST),
		.ce(CE),
		.d({SLAVE_PIN, CONTROL_PIN, SYNC_PIN}),
		.q(pins_s)
	);
	assign sync_s = pins_s[0];
	assign ctl_s = pins_s[1];
	assign slave_s = pins_s[2];

	csc_timebase u_tb (
		.clk(CLK),
		.rst(RST),
		.ce(CE),
		.clr(tb_clr),
		.us_tick(us_tick),
		.ms_tick(ms_tick)
	);

	// ----------------------------------------------------------------
	// configuration registers
	// ----------------------------------------------------------------
	logic [7:0] op_r, cfg_r, ton_dly_r, ton_rise_r, toff_dly_r, toff_fall_r;
	logic [7:0] lim_r;
	logic [15:0] input_turn_on_threshold_r, input_turn_off_threshold_r;

	function automatic logic [15:0] snap_mv(input logic [15:0] v,
		input logic [15:0] lo, input logic [15:0] hi);
		logic [15:0] c;
		c = (v < lo) ? lo : ((v > hi) ? hi : v);
		snap_mv = c - ((c - lo) % `CSC_VIN_STEP);
	endfunction : snap_mv

	function automatic logic [7:0] clamp_ms(input logic [15:0] v,
		input logic [7:0] lo);
		clamp_ms = (v > 16'(`CSC_MS_MAX)) ? `CSC_MS_MAX :
			((v < 16'(lo)) ? lo : v[7:0]);
	endfunction : clamp_ms

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			op_r <= `CSC_OP_DEF;
			cfg_r <= `CSC_CFG_DEF;
			input_turn_on_threshold_r <= `CSC_INPUT_TURN_ON_THRESHOLD_DEF;
			input_turn_off_threshold_r <= `CSC_INPUT_TURN_OFF_THRESHOLD_DEF;
			ton_dly_r <= `CSC_TON_DELAY_DEF;
			ton_rise_r <= `CSC_TON_RISE_DEF;
			toff_dly_r <= `CSC_TOFF_DELAY_DEF;
			toff_fall_r <= `CSC_TOFF_FALL_DEF;
			lim_r <= `CSC_LIMITS_DEF;
		end else if (CE && CMD_WR) begin
			case (CMD_CODE)
			`CSC_CMD_OPERATION: op_r <= CMD_DATA[7:0];
			`CSC_CMD_ON_OFF_CFG: cfg_r <= CMD_DATA[7:0];
			`CSC_CMD_INPUT_TURN_ON_THRESHOLD: input_turn_on_threshold_r <= snap_mv(CMD_DATA,
				`CSC_INPUT_TURN_ON_THRESHOLD_MIN, `CSC_INPUT_TURN_ON_THRESHOLD_MAX);
			`CSC_CMD_INPUT_TURN_OFF_THRESHOLD: input_turn_off_threshold_r <= snap_mv(CMD_DATA,
				`CSC_INPUT_TURN_OFF_THRESHOLD_MIN, `CSC_INPUT_TURN_OFF_THRESHOLD_MAX);
			`CSC_CMD_TON_DELAY: ton_dly_r <= clamp_ms(CMD_DATA, 8'h00);
			`CSC_CMD_TON_RISE: ton_rise_r <= clamp_ms(CMD_DATA,
				`CSC_MS_ONE);
			`CSC_CMD_TOFF_DELAY: toff_dly_r <= clamp_ms(CMD_DATA, 8'h00);
			`CSC_CMD_TOFF_FALL: toff_fall_r <= clamp_ms(CMD_DATA, 8'h00);
			`CSC_CMD_GOOD_LIMITS: lim_r <= CMD_DATA[7:0];
			default: ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// input lockout and gating
	// ----------------------------------------------------------------
	logic uvlo_ok_r, gate, gate_d_r, pin_on, off_by_op;

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			uvlo_ok_r <= 1'b0;
		end else if (CE) begin
			// hysteresis between the two thresholds
			if (VIN_MV >= input_turn_on_threshold_r)
				uvlo_ok_r <= 1'b1;
			else if (VIN_MV < input_turn_off_threshold_r)
				uvlo_ok_r <= 1'b0;
		end
	end

	assign pin_on = cfg_r[`CSC_CFG_POL] ? ctl_s : ~ctl_s;
	assign gate = uvlo_ok_r & (~cfg_r[`CSC_CFG_PU] |
		((~cfg_r[`CSC_CFG_CMD] | op_r[`CSC_OP_ON]) &
		(~cfg_r[`CSC_CFG_PIN] | pin_on)));
	assign off_by_op = cfg_r[`CSC_CFG_PU] & cfg_r[`CSC_CFG_CMD] &
		~op_r[`CSC_OP_ON];

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	csc_state_type state_r, state_nxt;
	logic [7:0] dly_r;
	logic [15:0] ref_r;
	logic skip_stop, sw_en, start_ok_r;

	// skip the controlled discharge per the cause of the stop
	assign skip_stop = off_by_op ? op_r[`CSC_OP_SKIP] :
		cfg_r[`CSC_CFG_CPA];

	always_comb begin
		state_nxt = state_r;
		case (state_r)
		ST_OFF:
			if (gate && !FAULT)
				state_nxt = ST_TON_WAIT;
		ST_TON_WAIT:
			if (!gate || FAULT)
				state_nxt = ST_OFF;
			else if (dly_r >= ton_dly_r)
				state_nxt = ST_RAMP_UP;
		ST_RAMP_UP, ST_ON:
			if (FAULT)
				state_nxt = cfg_r[`CSC_CFG_CPA] ? ST_OFF :
					ST_RAMP_DOWN;
			else if (!gate)
				state_nxt = ST_TOFF_WAIT;
			else if (state_r == ST_RAMP_UP && ref_r >= VREF_MV)
				state_nxt = ST_ON;
		ST_TOFF_WAIT:
			if (FAULT)
				state_nxt = cfg_r[`CSC_CFG_CPA] ? ST_OFF : ST_RAMP_DOWN;
			else if (gate)
				state_nxt = (ref_r >= VREF_MV) ? ST_ON : ST_RAMP_UP;
			else if (dly_r >= toff_dly_r)
				state_nxt = skip_stop ? ST_OFF :
					ST_RAMP_DOWN;
		ST_RAMP_DOWN:
			if (ref_r <= `CSC_TRISTATE_MV)
				state_nxt = ST_OFF;
		default: state_nxt = ST_OFF;
		endcase
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			state_r <= ST_OFF;
			gate_d_r <= 1'b0;
		end else if (CE) begin
			state_r <= state_nxt;
			gate_d_r <= gate;
		end
	end

	// delays count whole milliseconds from the latest change
	assign tb_clr = (gate != gate_d_r) || (state_nxt != state_r);

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			dly_r <= 8'h00;
		end else if (CE) begin
			if (tb_clr)
				dly_r <= 8'h00;
			else if (ms_tick && dly_r != 8'hff)
				dly_r <= dly_r + 8'h01;
		end
	end

	// ----------------------------------------------------------------
	// soft start / soft stop reference ramp
	// ----------------------------------------------------------------
	// the ramp adds the final value each microsecond and spends it one
	// millivolt per cycle, so a full ramp takes the set time, or 1 ms when the fall time is 0
	logic [23:0] acc_r, acc_add;
	logic [16:0] den;
	logic [7:0] fall_eff;
	logic step;

	assign fall_eff = (toff_fall_r == 8'h00) ? `CSC_MS_ONE :
		toff_fall_r;
	assign den = 17'(32'((state_r == ST_RAMP_DOWN) ? fall_eff :
		ton_rise_r) * `CSC_MS_US);
	assign step = acc_r >= 24'(den);
	assign acc_add = us_tick ? 24'(VREF_MV) : 24'h000000;

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			acc_r <= 24'h000000;
			ref_r <= 16'h0000;
		end else if (CE) begin
			case (state_r)
			ST_RAMP_UP: begin
				acc_r <= acc_r + acc_add - (step ? 24'(den) : 24'h000000);
				if (step && ref_r < VREF_MV)
					ref_r <= ref_r + 16'h0001;
			end
			ST_RAMP_DOWN: begin
				acc_r <= acc_r + acc_add - (step ? 24'(den) : 24'h000000);
				if (step && ref_r != 16'h0000)
					ref_r <= ref_r - 16'h0001;
			end
			ST_ON: begin
				acc_r <= 24'h000000;
				ref_r <= VREF_MV;
			end
			// hold the level: a stop cut short must not jump the output up
			ST_TOFF_WAIT: acc_r <= 24'h000000;
			default: begin
				acc_r <= 24'h000000;
				ref_r <= 16'h0000;
			end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// prebias start
	// ----------------------------------------------------------------
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			start_ok_r <= 1'b0;
		end else if (CE) begin
			if (state_r == ST_OFF || state_r == ST_TON_WAIT)
				start_ok_r <= 1'b0;
			else if (state_r == ST_RAMP_UP && ref_r > FB_MV)
				start_ok_r <= 1'b1;
		end
	end

	// tri-state whenever the sequencer is off or the ramp is behind
	assign sw_en = start_ok_r && state_r != ST_OFF &&
		state_r != ST_TON_WAIT;

	// ----------------------------------------------------------------
	// sync lock and loss detection
	// ----------------------------------------------------------------
	logic sync_edge, in_rng, too_long, lag_fire;
	logic [12:0] per_r;
	logic [1:0] good_r;
	logic [5:0] lag_r;
	logic [11:0] ph_r;
	logic cyc_start;

	// only the second flop's output and its delayed copy are used here
	assign sync_edge = slave_s ? (sync_d_r & ~sync_s) :
		(~sync_d_r & sync_s);
	assign in_rng = (16'(per_r) * 16'd5 >= 16'(FREE_PERIOD) * 16'd4) &&
		(16'(per_r) * 16'd5 <= 16'(FREE_PERIOD) * 16'd6);
	assign too_long = 16'(per_r) * 16'd5 > 16'(FREE_PERIOD) * 16'd6;

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			sync_d_r <= 1'b0;
			per_r <= 13'h0000;
			good_r <= 2'h0;
			SYNC_LOCKED <= 1'b0;
		end else if (CE) begin
			sync_d_r <= sync_s;
			if (sync_edge) begin
				per_r <= 13'h0001;
				if (in_rng) begin
					if (good_r != 2'h3)
						good_r <= good_r + 2'h1;
					if (good_r != 2'h0)
						SYNC_LOCKED <= 1'b1;
				end else begin
					good_r <= 2'h0;
					SYNC_LOCKED <= 1'b0;
				end
			end else begin
				if (per_r != 13'h1fff)
					per_r <= per_r + 13'h0001;
				if (too_long) begin
					// an edge overdue by more than the window: clock lost
					good_r <= 2'h0;
					SYNC_LOCKED <= 1'b0;
				end
			end
		end
	end

	// switching-period start: sync edge plus fixed lag, or free-run
	assign lag_fire = (lag_r == 6'h01);
	assign cyc_start = SYNC_LOCKED ? lag_fire :
		(ph_r >= FREE_PERIOD - 12'h001);

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			lag_r <= 6'h00;
			ph_r <= 12'h000;
		end else if (CE) begin
			if (SYNC_LOCKED && sync_edge)
				lag_r <= 6'(`CSC_SYNC_LAG_CYC);
			else if (lag_r != 6'h00)
				lag_r <= lag_r - 6'h01;
			if (cyc_start)
				ph_r <= 12'h000;
			else if (ph_r != 12'hfff)
				ph_r <= ph_r + 12'h001;
		end
	end

	// ----------------------------------------------------------------
	// gate drive with low-side widening after start
	// ----------------------------------------------------------------
	logic [7:0] pcnt_r;
	logic [11:0] off_len;
	logic [12:0] ls_allow;
	logic ls_full;

	assign off_len = (FREE_PERIOD > DUTY) ? FREE_PERIOD - DUTY : 12'h000;
	assign ls_allow = 13'((20'(off_len) * 20'(pcnt_r)) >> 7);
	assign ls_full = (pcnt_r == `CSC_PREBIAS_PULSES);

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			pcnt_r <= 8'h00;
			HS_GATE <= 1'b0;
			LS_GATE <= 1'b0;
			CONVERTING <= 1'b0;
		end else if (CE) begin
			CONVERTING <= sw_en;
			if (!sw_en)
				pcnt_r <= 8'h00;
			else if (cyc_start && !ls_full)
				pcnt_r <= pcnt_r + 8'h01;
			HS_GATE <= sw_en && ph_r < DUTY;
			LS_GATE <= sw_en && ph_r >= DUTY && (ls_full ||
				13'(ph_r - DUTY) < ls_allow);
		end
	end

	// ----------------------------------------------------------------
	// overvoltage warning and power-good
	// ----------------------------------------------------------------
	logic [31:0] fb_pct, hi_lim, lo_lim, ovw_lim;
	logic overvoltage_warning, in_win;

	assign fb_pct = 32'(FB_MV) * 32'd100;
	assign ovw_lim = 32'(VREF_MV) * `CSC_OVW_PCT;
	assign hi_lim = 32'(VREF_MV) * (32'd100 + 32'(lim_r[7:4]));
	assign lo_lim = 32'(VREF_MV) * (32'd100 - 32'(lim_r[3:0]));
	assign overvoltage_warning = BP6_MV > `CSC_BP6_UVLO_MV && fb_pct > ovw_lim;
	assign in_win = fb_pct <= hi_lim && fb_pct >= lo_lim;

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			OV_WARN <= 1'b0;
			POWER_GOOD_OE_N <= 1'b0;
			SS_REF_MV <= 16'h0000;
		end else if (CE) begin
			OV_WARN <= overvoltage_warning;
			// pull low unless in regulation, inside window, no overvoltage warning, fault-free
			POWER_GOOD_OE_N <= state_r == ST_ON && in_win && !overvoltage_warning &&
				!FAULT;
			SS_REF_MV <= ref_r;
		end
	end
	assign POWER_GOOD_O = 1'b0;

	// ----------------------------------------------------------------
	// read-back
	// ----------------------------------------------------------------
	logic [15:0] status;

	assign status = {5'h00, 3'(state_r), 2'h0, FAULT, CONVERTING,
		POWER_GOOD_OE_N, OV_WARN, uvlo_ok_r, SYNC_LOCKED};

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			RD_DATA <= 16'h0000;
			RD_ACK <= 1'b0;
		end else if (CE) begin
			RD_ACK <= CMD_RD;
			if (CMD_RD) begin
				case (CMD_CODE)
				`CSC_CMD_OPERATION: RD_DATA <= {8'h00, op_r};
				`CSC_CMD_ON_OFF_CFG: RD_DATA <= {8'h00, cfg_r};
				`CSC_CMD_INPUT_TURN_ON_THRESHOLD: RD_DATA <= input_turn_on_threshold_r;
				`CSC_CMD_INPUT_TURN_OFF_THRESHOLD: RD_DATA <= input_turn_off_threshold_r;
				`CSC_CMD_TON_DELAY: RD_DATA <= {8'h00, ton_dly_r};
				`CSC_CMD_TON_RISE: RD_DATA <= {8'h00, ton_rise_r};
				`CSC_CMD_TOFF_DELAY: RD_DATA <= {8'h00, toff_dly_r};
				`CSC_CMD_TOFF_FALL: RD_DATA <= {8'h00, toff_fall_r};
				`CSC_CMD_GOOD_LIMITS: RD_DATA <= {8'h00, lim_r};
				`CSC_CMD_STATUS: RD_DATA <= status;
				default: RD_DATA <= 16'h0000;
				endcase
			end
		end
	end
endmodule : csc_top

//--- tb/csc_props.sv
// checker for the converter sequencing control ports
// assumes a bind to csc_top and CE held high
`timescale 1ns/1ps
module csc_props (
	input wire logic CLK, // clock
	input wire logic RST, // async reset
	input wire logic SYNC_PIN, // sync pin
	input wire logic [15:0] FB_MV, // feedback
	input wire logic [15:0] VREF_MV, // reference
	input wire logic [15:0] BP6_MV, // regulator
	input wire logic [11:0] FREE_PERIOD, // free period
	input wire logic FAULT, // fault
	input wire logic HS_GATE, // high side
	input wire logic LS_GATE, // low side
	input wire logic POWER_GOOD_OE_N, // good released
	input wire logic OV_WARN, // ov warning
	input wire logic SYNC_LOCKED, // locked
	input wire logic CONVERTING // switching
);
	logic [15:0] idle_r;
	logic sync_d_r;
	logic [15:0] lost_lim;
	// raw pin age, less the synchroniser lag, bounds the synced edge age from below
	assign lost_lim = 16'(FREE_PERIOD) * 16'h000c / 16'h000a + 16'h0008;
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			sync_d_r <= 1'b0;
			idle_r <= 16'h0000;
		end else begin
			sync_d_r <= SYNC_PIN;
			if (SYNC_PIN != sync_d_r)
				idle_r <= 16'h0000;
			else if (idle_r != 16'hffff)
				idle_r <= idle_r + 16'h0001;
		end
	end
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);
	a_no_overlap: assert property (!(HS_GATE && LS_GATE))
		else $error("both drivers on");
	a_off_tristate: assert property (
		!CONVERTING && !$past(CONVERTING) |-> !HS_GATE && !LS_GATE)
		else $error("drivers on while off");
	a_pg_fault: assert property (POWER_GOOD_OE_N |-> !$past(FAULT))
		else $error("good during fault");
	a_pg_active: assert property (POWER_GOOD_OE_N |-> $past(CONVERTING))
		else $error("good while off");
	a_pg_window: assert property (POWER_GOOD_OE_N |->
		32'($past(FB_MV)) * 100 <= 32'($past(VREF_MV)) * 115)
		else $error("good above window");
	a_ovw_set: assert property (BP6_MV > 16'h0e92 &&
		32'(FB_MV) * 100 > 32'(VREF_MV) * 105 |=> OV_WARN)
		else $error("ov warning missed");
	a_ovw_clear: assert property (BP6_MV <= 16'h0e92 ||
		32'(FB_MV) * 100 <= 32'(VREF_MV) * 105 |=> !OV_WARN)
		else $error("false ov warning");
	a_sync_lost: assert property (idle_r > lost_lim |-> !SYNC_LOCKED)
		else $error("lock kept without clock");
	a_lock_edge: assert property (
		$rose(SYNC_LOCKED) |-> idle_r < 16'h0010)
		else $error("lock without recent edge");
	c_locked: cover property ($rose(SYNC_LOCKED));
	c_conv: cover property ($rose(CONVERTING));
	c_ovw: cover property ($rose(OV_WARN));
endmodule : csc_props
bind csc_top csc_props u_props (.CLK, .RST, .SYNC_PIN, .FB_MV, .VREF_MV,
	.BP6_MV, .FREE_PERIOD, .FAULT, .HS_GATE, .LS_GATE, .POWER_GOOD_OE_N,
	.OV_WARN, .SYNC_LOCKED, .CONVERTING);

//--- tb/csc_sync_src.sv
// external switching clock source model
// assumes the bench gates it with en; 125 ns period
`timescale 1ns/1ps
module csc_sync_src (
	input wire logic en, // run the clock
	output logic sync_o // to the sync pin
);
	// parked low when idle: the source does not run free
	initial sync_o = 1'b0;
	always begin
		#62.5;
		sync_o = en ? ~sync_o : 1'b0;
	end
endmodule : csc_sync_src

//--- tb/tb_csc_top.sv
// self-checking bench for csc_top
// assumes csc_consts.svh on the include path
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
	mismatches++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb_csc_top;
	logic CLK = 1'b0, RST = 1'b1, CONTROL_PIN = 1'b0, FAULT = 1'b0;
	logic CMD_WR = 1'b0, CMD_RD = 1'b0, sync_en = 1'b0, SYNC_PIN;
	logic SLAVE_PIN = 1'b0;
	logic [7:0] CMD_CODE = 8'h00;
	logic [15:0] CMD_DATA = 16'h0000, VIN_MV = 16'h1388, FB_MV = 16'h0000;
	logic [15:0] VREF_MV = 16'h012c, BP6_MV = 16'h1388, RD_DATA, SS_REF_MV;
	logic RD_ACK, HS_GATE, LS_GATE, POWER_GOOD_O, POWER_GOOD_OE_N;
	logic OV_WARN, SYNC_LOCKED, CONVERTING;
	int mismatches = 0, check_count = 0, cycles = 0;
	// 16-cycle free period keeps the 125 ns source within range
	csc_top DUT (.CLK, .RST, .CE(1'b1), .SYNC_PIN, .CONTROL_PIN,
		.SLAVE_PIN, .VIN_MV, .FB_MV, .VREF_MV, .BP6_MV,
		.FREE_PERIOD(12'h010), .DUTY(12'h004), .FAULT, .CMD_WR, .CMD_RD,
		.CMD_CODE, .CMD_DATA, .RD_DATA, .RD_ACK, .HS_GATE, .LS_GATE,
		.SS_REF_MV, .POWER_GOOD_O, .POWER_GOOD_OE_N, .OV_WARN, .SYNC_LOCKED,
		.CONVERTING);
	csc_sync_src SRC (.en(sync_en), .sync_o(SYNC_PIN));
	always #4 CLK = ~CLK;
	always @(posedge CLK) begin
		cycles++;
		if (cycles == 40000) begin
			mismatches++;
			final_report();
		end
	end
	task automatic final_report();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : final_report
	task automatic wr(input logic [7:0] c, input logic [15:0] d);
		@(negedge CLK);
		CMD_WR = 1'b1;
		CMD_CODE = c;
		CMD_DATA = d;
		@(negedge CLK);
		CMD_WR = 1'b0;
	endtask : wr
	task automatic rd(input string n, input logic [7:0] c, input logic [15:0] e);
		@(negedge CLK);
		CMD_RD = 1'b1;
		CMD_CODE = c;
		@(negedge CLK);
		CMD_RD = 1'b0;
		for (int i = 0; i < 4 && RD_ACK !== 1'b1; i++) @(negedge CLK);
		`CHK(n, e, RD_DATA)
	endtask : rd
	task automatic wait_cycles(input int n);
		repeat (n) @(negedge CLK);
	endtask : wait_cycles
	// wait for the reference to pass 400 mV under a bound
	task automatic wait_ref();
		for (int i = 0; i < 4000 && !(SS_REF_MV > 16'h0190); i++) @(negedge CLK);
	endtask : wait_ref
	task automatic wait_off();
		for (int i = 0; i < 8 && CONVERTING !== 1'b0; i++) @(negedge CLK);
	endtask : wait_off
	// ramp fast on a high final value, then drop it so the ramp ends
	task automatic go_on();
		VREF_MV = 16'h7530;
		FB_MV = 16'h0000;
		wait_ref();
		VREF_MV = 16'h0190;
		FB_MV = 16'h0190;
		wait_cycles(4);
		`CHK("pg_on", 1'b1, POWER_GOOD_OE_N)
	endtask : go_on
	task automatic t_defaults();
		rd("input_turn_on_threshold", 8'h35, 16'h1194);
		rd("input_turn_off_threshold", 8'h36, 16'h0fa0);
		rd("toff_dly", 8'h64, 16'h0000);
		rd("toff_fall", 8'h65, 16'h0003);
		rd("limits", 8'hd7, 16'h0055);
		rd("cfg", 8'h02, 16'h0016);
		`CHK("pg_pad", 1'b0, POWER_GOOD_O)
		$display("t_defaults done");
	endtask : t_defaults
	task automatic t_clamp();
		wr(8'h35, 16'h0000);
		rd("on_min", 8'h35, 16'h109a);
		wr(8'h35, 16'hffff);
		rd("on_max", 8'h35, 16'h1e46);
		wr(8'h35, 16'h1130);
		rd("on_snap", 8'h35, 16'h109a);
		wr(8'h35, 16'h1200);
		rd("on_step", 8'h35, 16'h1194);
		wr(8'h36, 16'hffff);
		rd("off_max", 8'h36, 16'h1d4c);
		wr(8'h36, 16'h0000);
		rd("off_min", 8'h36, 16'h0fa0);
		wr(8'h60, 16'h00c8);
		rd("ton_max", 8'h60, 16'h0064);
		wr(8'h60, 16'h0000);
		wr(8'h61, 16'h0000);
		rd("rise_min", 8'h61, 16'h0001);
		$display("t_clamp done");
	endtask : t_clamp
	task automatic t_sync();
		// master pass, then slave pass locking to the falling edge
		for (int s = 0; s < 2; s++) begin
			SLAVE_PIN = s[0];
			`CHK("free_run", 1'b0, SYNC_LOCKED)
			sync_en = 1'b1;
			for (int i = 0; i < 400 && SYNC_LOCKED !== 1'b1; i++)
				@(negedge CLK);
			`CHK("locked", 1'b1, SYNC_LOCKED)
			sync_en = 1'b0;
			for (int i = 0; i < 100 && SYNC_LOCKED !== 1'b0; i++)
				@(negedge CLK);
			`CHK("lost", 1'b0, SYNC_LOCKED)
		end
		$display("t_sync done");
	endtask : t_sync
	task automatic t_ovw();
		FB_MV = 16'h0190;
		BP6_MV = 16'h0bb8;
		wait_cycles(3);
		`CHK("ovw_bp6", 1'b0, OV_WARN)
		BP6_MV = 16'h1388;
		wait_cycles(3);
		`CHK("ovw_set", 1'b1, OV_WARN)
		`CHK("pg_off", 1'b0, POWER_GOOD_OE_N)
		FB_MV = 16'h013b; // exactly 105 percent
		wait_cycles(3);
		`CHK("ovw_edge", 1'b0, OV_WARN)
		$display("t_ovw done");
	endtask : t_ovw
	task automatic t_prebias();
		int n;
		n = 0;
		FB_MV = 16'h0014;
		CONTROL_PIN = 1'b1;
		for (int i = 0; i < 20000 && HS_GATE !== 1'b1; i++) @(negedge CLK);
		`CHK("ref_gt_fb", 1'b1, SS_REF_MV >= FB_MV)
		`CHK("conv_pin", 1'b1, CONVERTING)
		repeat (32) begin
			@(negedge CLK);
			if (LS_GATE === 1'b1)
				n++;
		end
		`CHK("ls_narrow", 1'b1, n < 3)
		CONTROL_PIN = 1'b0;
		for (int i = 0; i < 200 && CONVERTING !== 1'b0; i++) @(negedge CLK);
		`CHK("pin_stop", 2'b00, {HS_GATE, LS_GATE})
		FB_MV = 16'h0000;
		$display("t_prebias done");
	endtask : t_prebias
	task automatic t_op_gate();
		wr(8'h02, 16'h0018);
		VIN_MV = 16'h0e10;
		wait_cycles(4);
		VIN_MV = 16'h1130; // between the two thresholds
		wr(8'h01, 16'h0080);
		wait_cycles(600);
		`CHK("uvlo_hold", 1'b0, CONVERTING)
		VIN_MV = 16'h1388;
		go_on();
		`CHK("op_on", 1'b1, CONVERTING)
		rd("status", 8'h79, 16'h031a);
		FB_MV = 16'h01a9; // above the 5 percent window edge
		wait_cycles(3);
		`CHK("pg_win", 1'b0, POWER_GOOD_OE_N)
		wr(8'h01, 16'h0040);
		wait_off();
		`CHK("op_skip", 3'b000, {CONVERTING, HS_GATE, LS_GATE})
		$display("t_op_gate done");
	endtask : t_op_gate
	task automatic t_fault();
		wr(8'h02, 16'h0019);
		wr(8'h01, 16'h0080);
		go_on();
		FAULT = 1'b1;
		wait_off();
		`CHK("cpa_off", 3'b000, {CONVERTING, HS_GATE, LS_GATE})
		`CHK("pg_fault", 1'b0, POWER_GOOD_OE_N)
		FAULT = 1'b0;
		wr(8'h01, 16'h0000);
		$display("t_fault done");
	endtask : t_fault
	initial begin
		wait_cycles(12);
		RST = 1'b0;
		t_defaults();
		t_clamp();
		t_sync();
		t_ovw();
		t_prebias();
		t_op_gate();
		t_fault();
		final_report();
	end
endmodule : tb_csc_top
